// ---- src/ccc_top.sv ----
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module ccc_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [15:0] sample_i,
  output logic irq_o
);
  ccc_pkg::ccc_ctrl_type ctrl;
  ccc_pkg::ccc_ctrl_type next_ctrl;
  ccc_pkg::ccc_stat_type stat;
  ccc_pkg::ccc_stat_type next_stat;
  logic [3:0] mask;
  logic [3:0] next_mask;
  logic go;
  logic next_go;
  logic go_vis;
  logic next_go_vis;
  logic rc_sel;
  logic next_rc_sel;
  logic [15:0] conversion_result;
  logic [15:0] next_result;
  logic [15:0] filter_result;
  logic [15:0] next_filter;
  logic [15:0] previous_sample;
  logic [15:0] next_prev;
  logic [23:0] accumulator;
  logic [23:0] next_acc;
  logic accum_overflow_flag;
  logic next_ovf;
  logic [7:0] sample_counter;
  logic [7:0] next_cnt;
  logic [15:0] thresh;
  logic [15:0] next_thresh;
  logic ack;
  logic next_ack;
  logic [31:0] next_rdata;
  logic start;
  logic busy;
  logic done;
  logic [2:0] shamt;
  logic [24:0] sum;
  logic [23:0] shifted;
  logic [23:0] lpf;
  logic wr;
  logic [3:0] set_ev;

  // One wait cycle per access: waitrequest drops in the second cycle.
  assign waitrequest = (read | write) & ~ack;
  // A write lands at the edge where waitrequest is sampled low.
  assign wr = write & ack;
  assign start = go & ~busy & ~done;
  // Reserved shift codes fall back to the largest usable shift.
  assign shamt = (ctrl.shift > ccc_pkg::SHIFT_MAX) ?
                 ccc_pkg::SHIFT_MAX : ctrl.shift;
  assign sum = {1'b0, accumulator} + {9'h000, sample_i};
  // Plain right shift drops the low bits, so division truncates.
  assign shifted = sum[23:0] >> shamt;
  // Unity-gain first-order filter with time constant 2^shift.
  assign lpf = {8'h00, filter_result} +
               (({8'h00, sample_i} >> shamt) -
                ({8'h00, filter_result} >> shamt));
  assign irq_o = |(stat & mask);

  ccc_core u_core (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(start),
    .busy_o(busy),
    .done_o(done)
  );

  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_thresh = thresh;
    next_go = go;
    next_rc_sel = rc_sel;
    next_ack = (read | write) & ~ack;
    next_rdata = 32'h0000_0000;
    next_result = conversion_result;
    next_filter = filter_result;
    next_prev = previous_sample;
    next_acc = accumulator;
    next_ovf = accum_overflow_flag;
    next_cnt = sample_counter;
    set_ev = 4'h0;
    next_stat = stat;
    if (start) begin
      next_prev = ctrl.psis ? filter_result :
                  conversion_result;
    end
    if (done) begin
      next_go = 1'b0;
      next_result = sample_i;
      set_ev[3] = 1'b1;
      case (ctrl.mode)
        ccc_pkg::MODE_BASIC: begin
          next_filter = filter_result;
        end
        ccc_pkg::MODE_ACC, ccc_pkg::MODE_AVG, ccc_pkg::MODE_BURST: begin
          next_acc = sum[23:0];
          next_ovf = accum_overflow_flag | sum[24];
          next_cnt = sample_counter + 8'h01;
          next_filter = shifted[15:0];
          set_ev[1] = (shifted[15:0] > thresh);
          set_ev[2] = sum[24];
        end
        ccc_pkg::MODE_LPF: begin
          next_filter = lpf[15:0];
          set_ev[1] = (lpf[15:0] > thresh);
        end
        default: begin
          next_filter = filter_result;
        end
      endcase
    end
    // A clear outranks a sample that completes in the same cycle.
    if (ctrl.clr) begin
      next_acc = 24'h00_0000;
      next_ovf = 1'b0;
      next_cnt = 8'h00;
      next_ctrl.clr = 1'b0;
      set_ev[0] = 1'b1;
    end
    if (wr) begin
      case (address)
        ccc_pkg::ADDR_CTRL: begin
          next_ctrl = ccc_pkg::ccc_ctrl_type'(writedata[7:0]);
          // A clear in flight has already run, so zero cannot cancel it.
          next_ctrl.clr = writedata[ccc_pkg::POS_CLR];
        end
        ccc_pkg::ADDR_MAIN: begin
          next_rc_sel = writedata[ccc_pkg::POS_RC];
          if (writedata[ccc_pkg::POS_GO]) begin
            next_go = 1'b1;
          end
        end
        ccc_pkg::ADDR_STAT: begin
          next_stat = stat & ~ccc_pkg::ccc_stat_type'(writedata[3:0]);
        end
        ccc_pkg::ADDR_MASK: begin
          next_mask = writedata[3:0];
        end
        ccc_pkg::ADDR_THR: begin
          next_thresh = writedata[15:0];
        end
        default: begin
          next_mask = mask;
        end
      endcase
    end
    // Setting wins over a simultaneous clear.
    next_stat = next_stat | ccc_pkg::ccc_stat_type'(set_ev);
    // With the RC clock the set go bit reads back one cycle later.
    next_go_vis = next_rc_sel ? (go & next_go) : next_go;
    if (read & ~ack) begin
      case (address)
        ccc_pkg::ADDR_CTRL: next_rdata = {24'h00_0000, ctrl};
        ccc_pkg::ADDR_MAIN: next_rdata = {30'h0, rc_sel, go_vis};
        ccc_pkg::ADDR_STAT: next_rdata = {28'h000_0000, stat};
        ccc_pkg::ADDR_MASK: next_rdata = {28'h000_0000, mask};
        ccc_pkg::ADDR_FILT: next_rdata = {16'h0000, filter_result};
        ccc_pkg::ADDR_PREV: next_rdata = {16'h0000, previous_sample};
        ccc_pkg::ADDR_ACC: next_rdata = {7'h00, accum_overflow_flag,
                                         accumulator};
        ccc_pkg::ADDR_CNT: next_rdata = {24'h00_0000, sample_counter};
        ccc_pkg::ADDR_THR: next_rdata = {16'h0000, thresh};
        ccc_pkg::ADDR_RES: next_rdata = {16'h0000, conversion_result};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl <= ccc_pkg::CTRL_RESET;
      stat <= ccc_pkg::STAT_RESET;
      mask <= 4'h0;
      thresh <= 16'h0000;
      go <= 1'b0;
      go_vis <= 1'b0;
      rc_sel <= 1'b0;
      ack <= 1'b0;
      readdata <= 32'h0000_0000;
      conversion_result <= 16'h0000;
      filter_result <= 16'h0000;
      previous_sample <= 16'h0000;
      accumulator <= 24'h00_0000;
      accum_overflow_flag <= 1'b0;
      sample_counter <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      stat <= next_stat;
      mask <= next_mask;
      thresh <= next_thresh;
      go <= next_go;
      go_vis <= next_go_vis;
      rc_sel <= next_rc_sel;
      ack <= next_ack;
      readdata <= (read & ~ack) ? next_rdata : readdata;
      conversion_result <= next_result;
      filter_result <= next_filter;
      previous_sample <= next_prev;
      accumulator <= next_acc;
      accum_overflow_flag <= next_ovf;
      sample_counter <= next_cnt;
    end
  end

  a_clear_self: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ctrl.clr |=> !ctrl.clr && accumulator == 24'h00_0000
    && sample_counter == 8'h00)
    else $error("accumulator clear did not complete");
  a_clear_flag: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ctrl.clr |=> stat.clr_done)
    else $error("clear done flag not set");
  a_clear_zero: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    wr && address == ccc_pkg::ADDR_CTRL && !writedata[ccc_pkg::POS_CLR]
    && !ctrl.clr && !done |=> $stable(accumulator)
    && $stable(sample_counter))
    else $error("writing zero to clear changed state");
  a_prev_src: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    start |=> previous_sample == ($past(ctrl.psis) ?
    $past(filter_result) : $past(conversion_result)))
    else $error("previous sample source wrong");
  a_prev_hold: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !start |=> $stable(previous_sample))
    else $error("previous sample changed without start");
  a_go_set: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    wr && address == ccc_pkg::ADDR_MAIN && writedata[ccc_pkg::POS_GO]
    |=> go)
    else $error("go not set by write");
  a_go_done: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done && !(wr && address == ccc_pkg::ADDR_MAIN) |=> !go)
    else $error("go not cleared at done");
  a_result_load: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done |=> conversion_result == $past(sample_i))
    else $error("conversion result not loaded at done");
  a_rc_delay: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    rc_sel && $rose(go) |-> !go_vis ##1 go_vis || !go)
    else $error("rc go visibility delay wrong");
  a_go_direct: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !rc_sel |-> go_vis == go)
    else $error("go read back wrong with system clock");
  a_go_rc: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    rc_sel |-> go_vis == (go && $past(go)))
    else $error("go read back wrong with rc clock");
  a_basic_hold: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done && ctrl.mode == ccc_pkg::MODE_BASIC && !ctrl.clr
    |=> $stable(accumulator))
    else $error("basic mode accumulated");
  a_basic_count: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done && ctrl.mode == ccc_pkg::MODE_BASIC && !ctrl.clr
    |=> $stable(sample_counter))
    else $error("basic mode counted a sample");
  a_basic_filter: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done && ctrl.mode == ccc_pkg::MODE_BASIC
    |=> $stable(filter_result))
    else $error("basic mode changed filter result");
  a_acc_count: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done && ctrl.mode == ccc_pkg::MODE_ACC && !ctrl.clr
    |=> sample_counter == $past(sample_counter) + 8'h01)
    else $error("sample counter not incremented");
  a_acc_sum: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done && ctrl.mode == ccc_pkg::MODE_ACC && !ctrl.clr
    |=> accumulator == $past(accumulator) + 24'($past(sample_i)))
    else $error("sample not added to accumulator");
  a_filt_shift: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done && ctrl.mode == ccc_pkg::MODE_ACC && !ctrl.clr
    && ctrl.shift <= ccc_pkg::SHIFT_MAX
    |=> filter_result == 16'(accumulator >> $past(ctrl.shift)))
    else $error("filter result not shifted accumulator");
  a_avg_shift: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done && (ctrl.mode == ccc_pkg::MODE_AVG
    || ctrl.mode == ccc_pkg::MODE_BURST) && !ctrl.clr
    && ctrl.shift <= ccc_pkg::SHIFT_MAX
    |=> filter_result == 16'(accumulator >> $past(ctrl.shift)))
    else $error("average result not shifted accumulator");
  a_lpf_unity: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done && ctrl.mode == ccc_pkg::MODE_LPF && sample_i == filter_result
    |=> $stable(filter_result))
    else $error("filter gain not unity");
  a_rsvd_mode: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done && ctrl.mode > ccc_pkg::MODE_LPF && !ctrl.clr
    |=> $stable(accumulator) && $stable(filter_result))
    else $error("reserved mode corrupted state");
  a_rsvd_count: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    done && ctrl.mode > ccc_pkg::MODE_LPF && !ctrl.clr
    |=> $stable(sample_counter))
    else $error("reserved mode counted a sample");
endmodule

// ---- src/ccc_pkg.sv ----
// Behaviour
// - Select one: filter result feeds previous sample.
// - Select zero: conversion result feeds previous sample.
// - Shift field bits 6:4; 110, 111 reserved.
// - Filter mode: time constant two to shift.
// - Shift only in modes 001, 010, 011; the code also applies the shift in filter mode 100.
// - Shift divisions truncate, never round.
// - Clear bit clears accumulator, overflow, counter; self-clears.
// - Mode field bits 2:0, 101-111 reserved.
// - Conversion done shown by go bit clearing.
// - RC clock: go set visible one cycle late.
// - Basic mode: no accumulation nor filtering.
// - Accumulate mode adds result, increments counter.
// - After accumulation update filter, threshold compare.
package ccc_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MAIN = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;
  localparam logic [3:0] ADDR_FILT = 4'h4;
  localparam logic [3:0] ADDR_PREV = 4'h5;
  localparam logic [3:0] ADDR_ACC = 4'h6;
  localparam logic [3:0] ADDR_CNT = 4'h7;
  localparam logic [3:0] ADDR_THR = 4'h8;
  localparam logic [3:0] ADDR_RES = 4'h9;
  localparam int POS_PSIS = 7;
  localparam int POS_CLR = 3;
  localparam int POS_GO = 0;
  localparam int POS_RC = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] MODE_BASIC = 3'h0;
  localparam logic [2:0] MODE_ACC = 3'h1;
  localparam logic [2:0] MODE_AVG = 3'h2;
  localparam logic [2:0] MODE_BURST = 3'h3;
  localparam logic [2:0] MODE_LPF = 3'h4;
  localparam logic [2:0] SHIFT_MAX = 3'h5;
  localparam logic [3:0] CONV_CYCLES = 4'hb;
  localparam logic [3:0] STAT_RESET = 4'h0;
  typedef struct packed {
    logic psis;
    logic [2:0] shift;
    logic clr;
    logic [2:0] mode;
  } ccc_ctrl_type;
  typedef struct packed {
    logic done;
    logic thresh;
    logic ovf;
    logic clr_done;
  } ccc_stat_type;
endpackage

// ---- src/ccc_core.sv ----
`timescale 1ns/1ps
// Conversion timer: counts a conversion and pulses done at its end.
module ccc_core (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic next_done;
  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
      next_done = (cnt == 4'h1);
    end else if (start_i) begin
      next_cnt = ccc_pkg::CONV_CYCLES;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      done_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done_o <= next_done;
    end
  end
  assign busy_o = (cnt != 4'h0);
endmodule

// ---- test/test_converter_compute_control.sv ----
`timescale 1ns/1ps
module test_converter_compute_control;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic [15:0] sample_i = 16'h0000;
  logic irq_o;
  logic [31:0] q;
  int fail_count = 0;
  int compares = 0;

  always #2.5 mclk_i = ~mclk_i;

  ccc_top i_dut (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .sample_i(sample_i),
    .irq_o(irq_o)
  );

  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; the request is held until waitrequest is low.
  task automatic bus(input logic [3:0] a, input logic wr,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    chk({31'h0, waitrequest}, 32'h0000_0000);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0000_0000);
    chk(q, exp);
  endtask

  // Starts a conversion on sample s and polls the go bit until it clears.
  task automatic conv(input logic [15:0] s);
    int n;
    n = 0;
    sample_i <= s;
    bus(ccc_pkg::ADDR_MAIN, 1'b1, 32'h0000_0001);
    do begin
      bus(ccc_pkg::ADDR_MAIN, 1'b0, 32'h0000_0000);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    chk({31'h0, q[0]}, 32'h0000_0000);
  endtask

  // Reads accumulator, counter and filter result in one go.
  task automatic acc3(input logic [31:0] a, input logic [31:0] c,
                      input logic [31:0] f);
    rd(ccc_pkg::ADDR_ACC, a);
    rd(ccc_pkg::ADDR_CNT, c);
    rd(ccc_pkg::ADDR_FILT, f);
  endtask

  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(ccc_pkg::ADDR_CTRL, 32'h0000_0000);
    rd(ccc_pkg::ADDR_STAT, 32'h0000_0000);
    chk({31'h0, irq_o}, 32'h0000_0000);
    rd(4'hf, 32'h0000_0000);
    bus(4'hf, 1'b1, 32'hffff_ffff);
    rd(4'hf, 32'h0000_0000);
    $display("test reset done");
    bus(ccc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0019);
    rd(ccc_pkg::ADDR_CTRL, 32'h0000_0011);
    acc3(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    bus(ccc_pkg::ADDR_STAT, 1'b1, 32'h0000_000f);
    bus(ccc_pkg::ADDR_MASK, 1'b1, 32'h0000_0008);
    rd(ccc_pkg::ADDR_STAT, 32'h0000_0000);
    conv(16'h0007);
    acc3(32'h0000_0007, 32'h0000_0001, 32'h0000_0003);
    rd(ccc_pkg::ADDR_RES, 32'h0000_0007);
    rd(ccc_pkg::ADDR_STAT, 32'h0000_000a);
    chk({31'h0, irq_o}, 32'h0000_0001);
    bus(ccc_pkg::ADDR_STAT, 1'b1, 32'h0000_0008);
    rd(ccc_pkg::ADDR_STAT, 32'h0000_0002);
    chk({31'h0, irq_o}, 32'h0000_0000);
    $display("test accumulate done");
    bus(ccc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0091);
    conv(16'h0005);
    rd(ccc_pkg::ADDR_PREV, 32'h0000_0003);
    acc3(32'h0000_000c, 32'h0000_0002, 32'h0000_0006);
    bus(ccc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0011);
    conv(16'h0009);
    rd(ccc_pkg::ADDR_PREV, 32'h0000_0005);
    acc3(32'h0000_0015, 32'h0000_0003, 32'h0000_000a);
    $display("test previous sample done");
    bus(ccc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0002);
    conv(16'h0001);
    acc3(32'h0000_0016, 32'h0000_0004, 32'h0000_0016);
    bus(ccc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0023);
    conv(16'h0002);
    acc3(32'h0000_0018, 32'h0000_0005, 32'h0000_0006);
    bus(ccc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0020);
    conv(16'h0008);
    acc3(32'h0000_0018, 32'h0000_0005, 32'h0000_0006);
    $display("test modes done");
    bus(ccc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0075);
    conv(16'h0008);
    rd(ccc_pkg::ADDR_ACC, 32'h0000_0018);
    bus(ccc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001);
    rd(ccc_pkg::ADDR_ACC, 32'h0000_0018);
    bus(ccc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0009);
    acc3(32'h0000_0000, 32'h0000_0000, 32'h0000_0006);
    rd(ccc_pkg::ADDR_CTRL, 32'h0000_0001);
    $display("test clear done");
    bus(ccc_pkg::ADDR_STAT, 1'b1, 32'h0000_000f);
    bus(ccc_pkg::ADDR_THR, 1'b1, 32'h0000_0010);
    rd(ccc_pkg::ADDR_THR, 32'h0000_0010);
    bus(ccc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0014);
    conv(16'h000a);
    rd(ccc_pkg::ADDR_FILT, 32'h0000_0008);
    rd(ccc_pkg::ADDR_STAT, 32'h0000_0008);
    conv(16'h0008);
    rd(ccc_pkg::ADDR_FILT, 32'h0000_0008);
    $display("test filter done");
    bus(ccc_pkg::ADDR_MAIN, 1'b1, 32'h0000_0003);
    @(posedge mclk_i);
    chk({31'h0, i_dut.go}, 32'h0000_0001);
    chk({31'h0, i_dut.go_vis}, 32'h0000_0000);
    rd(ccc_pkg::ADDR_MAIN, 32'h0000_0003);
    repeat (20) @(posedge mclk_i);
    rd(ccc_pkg::ADDR_MAIN, 32'h0000_0002);
    $display("test rc clock done");
    stop_test();
  end

  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule
